/* bench/dspic_ctrl_props.sv */
// Purpose: Port checks of the interrupt controller
// Assumes: Bound to dspic_ctrl; sees its ports only
// Notes: One clock domain, so default clocking is used
`include "dspic_defines.vh"
`default_nettype none
module dspic_ctrl_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DSPIC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic flag_out_q,
  input wire logic irq_req_q,
  input wire logic [13:0] irq_vector_q,
  input wire logic irq_ack,
  input wire logic stack_ovf_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Helpers and properties
  // ********
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase and unmapped address decode
  wire logic acc = psel && penable;
  wire logic bad = paddr > `DSPIC_OFS_STAT || paddr[1:0] != 2'b00;
  wire logic wr = acc && pwrite;
  wire logic fo_bit = pwdata[3];
  a_pready_high: assert property (pready)
    else $error("pready low");
  a_slverr_map: assert property (pslverr == (acc && bad))
    else $error("pslverr does not match decode");
  a_reset_vector: assert property
    ($rose(presetn) |=> irq_req_q && irq_vector_q == 14'h0000)
    else $error("no reset vector after release");
  a_offer_holds: assert property
    (irq_req_q && !irq_ack |=> irq_req_q)
    else $error("offer withdrawn before ack");
  a_ack_drops: assert property
    (irq_req_q && irq_ack |=> !irq_req_q)
    else $error("offer stayed after ack");
  a_mask_block: assert property
    (wr && paddr == `DSPIC_OFS_MASK |=> ##1
     (!$rose(irq_req_q) || irq_vector_q == 14'h0000))
    else $error("offer right after mask write");
  a_vector_legal: assert property
    (irq_req_q |-> irq_vector_q[1:0] == 2'b00 && irq_vector_q <= 14'h002c)
    else $error("vector outside table");
  a_flag_follow: assert property
    (wr && paddr == `DSPIC_OFS_GCTL |=> ##1 flag_out_q == $past(fo_bit, 2))
    else $error("flag out not following write");
  a_ovf_sticky: assert property (stack_ovf_q |=> stack_ovf_q)
    else $error("overflow flag cleared");
endmodule
bind dspic_ctrl dspic_ctrl_props dspic_ctrl_props_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .flag_out_q(flag_out_q), .irq_req_q(irq_req_q),
  .irq_vector_q(irq_vector_q), .irq_ack(irq_ack),
  .stack_ovf_q(stack_ovf_q));
`default_nettype wire

/* bench/dspic_seq_model.sv */
// Purpose: Sequencer ack side and level request sources
// Assumes: Offer stays up until the ack is seen
// Notes: Slow mode waits three cycles before acking
`default_nettype none
module dspic_seq_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_req_q,
  input wire logic [13:0] irq_vector_q,
  input wire logic slow,
  input wire logic lvl_go,
  output logic irq_ack,
  output logic level_request_first_n,
  output logic level_request_second_n,
  output logic [13:0] last_vec_q,
  output logic [7:0] ack_cnt_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Ack and source logic
  // ********
  logic [1:0] wait_q; // Cycles the offer has waited
  wire logic took = irq_req_q && irq_ack;
  // One-cycle ack pulse, logged at the edge it is taken
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_ack <= 1'b0;
      wait_q <= 2'h0;
      ack_cnt_q <= 8'h00;
      last_vec_q <= 14'h0000;
      level_request_first_n <= 1'b1;
      level_request_second_n <= 1'b1;
    end
    else
    begin
      irq_ack <= irq_req_q && !irq_ack && (!slow || wait_q == 2'h3);
      wait_q <= (irq_req_q && !irq_ack) ? wait_q + 2'h1 : 2'h0;
      if (took)
      begin
        ack_cnt_q <= ack_cnt_q + 8'h01;
        last_vec_q <= irq_vector_q;
      end
      if (lvl_go)
      begin
        level_request_first_n <= 1'b0;
        level_request_second_n <= 1'b0;
      end
      if (took && irq_vector_q == 14'h000c)
        level_request_first_n <= 1'b1;
      if (took && irq_vector_q == 14'h0008)
        level_request_second_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
// Purpose: Self-checking bench of the interrupt controller
// Assumes: Zero-wait APB slave, model acks every offer
// Notes: Priority and alternate tests raise sources with global enable off, then drain
`include "dspic_defines.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Signals and instances
  // ********
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, irq_return = 1'b0, slow = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [13:0] ev = 14'h0; // Source pulses by source index
  logic [3:0] qh; // Offers seen while quiet
  logic [13:0] vtab [0:10] = '{14'h002c, 14'h0004, 14'h0008, 14'h000c,
    14'h0010, 14'h0014, 14'h0018, 14'h001c, 14'h0020, 14'h0024, 14'h0028};
  int num_errors = 0, compares = 0, acks = 0;
  wire logic [31:0] prdata_q;
  wire logic pready, pslverr, flag_out_q, irq_req_q, irq_ack, ovf, l1_n, l2_n;
  wire logic [13:0] irq_vector_q, last_vec_q;
  wire logic [7:0] ack_cnt_q;
  wire logic [15:0] status_out;
  wire logic [15:0] status_in = 16'h5a00 + {8'h00, ack_cnt_q};
  // Free-running 50 MHz clock
  always #10 pclk = ~pclk;
  dspic_ctrl dspic_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready(pready), .pslverr(pslverr),
    .ext_request_programmable_a_n(~ev[1]), .level_request_first_n(l1_n),
    .level_request_second_n(l2_n), .edge_request_pin_n(~ev[6]),
    .alt_request_receive_sync_n(~ev[12]), .flag_in(1'b1),
    .alt_request_transmit_sync_n(~ev[11]), .flag_out_q(flag_out_q),
    .sp0_tx_evt(ev[4]), .sp0_rx_evt(ev[5]), .sp1_tx_evt(ev[8]),
    .sp1_rx_evt(ev[9]), .byte_dma_port_evt(ev[7]), .timer_evt(ev[10]),
    .pdn_evt(ev[0]), .powerup_evt(ev[13]), .irq_req_q(irq_req_q),
    .irq_vector_q(irq_vector_q), .irq_ack(irq_ack), .status_in(status_in),
    .irq_return(irq_return), .status_out(status_out), .stack_ovf_q(ovf));
  dspic_seq_model dspic_seq_model_inst (.pclk(pclk), .presetn(presetn),
    .irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q), .slow(slow),
    .lvl_go(ev[2]), .irq_ack(irq_ack), .level_request_first_n(l1_n),
    .level_request_second_n(l2_n), .last_vec_q(last_vec_q),
    .ack_cnt_q(ack_cnt_q));
  // ********
  // Tasks
  // ********
  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Limit ran out: count it and close the run
  task automatic hang;
    num_errors++;
    finish_test();
  endtask
  // One APB transfer, request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50)
      hang();
    rd = prdata_q;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic [13:0] m);
    @(posedge pclk);
    ev <= m;
    repeat (2) @(posedge pclk);
    ev <= 14'h0;
  endtask
  task automatic wait_ack;
    int n;
    acks++;
    for (n = 0; n < 200 && ack_cnt_q !== acks[7:0]; n++)
      @(posedge pclk) #1;
    if (n == 200)
      hang();
  endtask
  task automatic ret;
    @(posedge pclk);
    irq_return <= 1'b1;
    @(posedge pclk);
    irq_return <= 1'b0;
    @(posedge pclk) #1;
  endtask
  task automatic quiet;
    qh = 4'h0;
    repeat (12) @(posedge pclk) #1 qh = qh + {3'b000, irq_req_q};
  endtask
  // Enable servicing, then take offers in table order
  task automatic drain(input logic [31:0] g, input int f, input int c);
    apb(1'b1, `DSPIC_OFS_GCTL, g);
    for (int i = f; i < f + c; i++)
    begin
      wait_ack();
      chk(last_vec_q, vtab[i]);
      ret();
      chk(status_out, 32'h5a00 + acks - 1);
    end
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    acks = 0;
    wait_ack();
    chk(last_vec_q, 32'h0);
    apb(1'b0, `DSPIC_OFS_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `DSPIC_OFS_GCTL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, `DSPIC_OFS_STAT, 32'h0);
    chk(rd & 32'h7f, 32'h40);
    chk(ovf, 1'b0);
  endtask
  // ********
  // Main sequence
  // ********
  initial
  begin
    do_reset();
    $display("test reset done");
    slow <= 1'b1;
    apb(1'b1, `DSPIC_OFS_GCTL, 32'h0);
    apb(1'b1, `DSPIC_OFS_CNTL, 32'h4);
    apb(1'b1, `DSPIC_OFS_MASK, 32'h7fe);
    pulse(14'h07ff);
    quiet();
    chk(qh, 32'h0);
    apb(1'b0, `DSPIC_OFS_PEND, 32'h0);
    chk(rd & 32'h7ff, 32'h7ff);
    drain(32'h1, 0, 11);
    $display("test priority done");
    slow <= 1'b0;
    apb(1'b1, `DSPIC_OFS_MASK, 32'h0);
    apb(1'b1, `DSPIC_OFS_FCLR, 32'h3);
    drain(32'h1, 0, 1);
    quiet();
    chk(qh, 32'h0);
    apb(1'b0, `DSPIC_OFS_PEND, 32'h0);
    chk(rd & 32'h7ff, 32'h2);
    apb(1'b1, `DSPIC_OFS_FCLR, 32'h0002_0000);
    apb(1'b0, `DSPIC_OFS_PEND, 32'h0);
    chk(rd & 32'h7ff, 32'h0);
    // Forced request unmasked by a write: one blocked cycle first
    apb(1'b1, `DSPIC_OFS_FCLR, 32'h2);
    apb(1'b1, `DSPIC_OFS_MASK, 32'h2);
    @(posedge pclk) #1;
    chk(irq_req_q, 1'b0);
    wait_ack();
    chk(last_vec_q, 32'h4);
    ret();
    apb(1'b0, `DSPIC_OFS_FCLR, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b0);
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
    $display("test force clear done");
    apb(1'b1, `DSPIC_OFS_MASK, 32'h7fe);
    pulse(14'h0400);
    wait_ack();
    chk(last_vec_q, 32'h28);
    pulse(14'h0002);
    quiet();
    chk(qh, 32'h0);
    ret();
    wait_ack();
    chk(last_vec_q, 32'h4);
    ret();
    apb(1'b1, `DSPIC_OFS_CNTL, 32'h14);
    pulse(14'h0400);
    wait_ack();
    pulse(14'h0002);
    wait_ack();
    chk(last_vec_q, 32'h4);
    apb(1'b0, `DSPIC_OFS_STAT, 32'h0);
    chk(rd & 32'hf, 32'h2);
    ret();
    chk(status_out, 32'h5a00 + acks - 1);
    ret();
    chk(status_out, 32'h5a00 + acks - 2);
    $display("test nesting done");
    apb(1'b1, `DSPIC_OFS_GCTL, 32'h2);
    apb(1'b1, `DSPIC_OFS_CNTL, 32'h7);
    pulse(14'h1800);
    drain(32'h3, 8, 2);
    apb(1'b1, `DSPIC_OFS_GCTL, 32'hd);
    pulse(14'h2000);
    wait_ack();
    chk(last_vec_q, 32'h0);
    chk(flag_out_q, 1'b1);
    $display("test alternate done");
    do_reset();
    $display("test second reset done");
    finish_test();
  end
endmodule
`default_nettype wire

/* verilog/dspic_ctrl.v */
// Purpose: Prioritising interrupt controller of the DSP core
// Assumes: Sequencer acknowledges vectors and signals returns
// Notes: APB slave with zero wait states
//
// Contract
// - Reset or power-up vector 0000, top priority
// - Power-down vector 002C, never masked
// - Pins vector 0004, 0008, 000C by priority
// - Serial0 0010/0014, edge 0018, byte DMA 001C
// - Serial1 or alternates 0020/0024, timer 0028
// - Eleven sources besides reset
// - Serial1 reconfigures into two alternates, flags
// - Internal priority, individual masks except fixed
// - Three inputs selectable edge or level
// - Control register holds nesting, sense bits
// - Nesting preempts, otherwise strictly sequential
// - Pending ANDed with mask, highest chosen
// - Mask write blocks interrupts one cycle
// - Write-only force/clear of pending requests
// - Twelve-deep status stack on entry, exit
// - Global enable gates all, power-down too
// - Global enable set after reset
// - Reset empties stack, masks all but power-down
`include "dspic_defines.vh"
`default_nettype none

module dspic_ctrl (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`DSPIC_AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output wire pready,
  output wire pslverr,
  input wire ext_request_programmable_a_n,
  input wire level_request_first_n,
  input wire level_request_second_n,
  input wire edge_request_pin_n,
  input wire alt_request_receive_sync_n,
  input wire alt_request_transmit_sync_n,
  input wire flag_in,
  output reg flag_out_q,
  input wire sp0_tx_evt,
  input wire sp0_rx_evt,
  input wire sp1_tx_evt,
  input wire sp1_rx_evt,
  input wire byte_dma_port_evt,
  input wire timer_evt,
  input wire pdn_evt,
  input wire powerup_evt,
  output reg irq_req_q,
  output reg [13:0] irq_vector_q,
  input wire irq_ack,
  input wire irq_return,
  input wire [`DSPIC_STW-1:0] status_in,
  output wire [`DSPIC_STW-1:0] status_out,
  output reg stack_ovf_q
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Index of the highest-priority set bit, none when empty
  function [3:0] first_set;
    input [`DSPIC_NSRC-1:0] v;
    integer i;
    begin
      first_set = `DSPIC_NONE;
      for (i = `DSPIC_NSRC - 1; i >= 0; i = i - 1)
      begin
        if (v[i])
        begin
          first_set = i[3:0];
        end
      end
    end
  endfunction

  // Vector address of a source index
  function [13:0] vec_of;
    input [3:0] s;
    begin
      case (s)
        `DSPIC_SRC_PDN: vec_of = `DSPIC_VEC_PDN;
        `DSPIC_SRC_EXTA: vec_of = `DSPIC_VEC_EXTA;
        `DSPIC_SRC_LVL2: vec_of = `DSPIC_VEC_LVL2;
        `DSPIC_SRC_LVL1: vec_of = `DSPIC_VEC_LVL1;
        `DSPIC_SRC_S0TX: vec_of = `DSPIC_VEC_S0TX;
        `DSPIC_SRC_S0RX: vec_of = `DSPIC_VEC_S0RX;
        `DSPIC_SRC_EDGE: vec_of = `DSPIC_VEC_EDGE;
        `DSPIC_SRC_BYTE_DMA_PORT: vec_of = `DSPIC_VEC_BYTE_DMA_PORT;
        `DSPIC_SRC_S1TX: vec_of = `DSPIC_VEC_S1TX;
        `DSPIC_SRC_S1RX: vec_of = `DSPIC_VEC_S1RX;
        default: vec_of = `DSPIC_VEC_TMR;
      endcase
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  reg [`DSPIC_NSRC-1:0] mask_q; // Bit 0 unused, power-down
  reg [4:0] cntl_q; // Sense and nesting control
  reg [3:0] gctl_q; // Global enable, alt mode, powerup_context_reset_bit, flag
  reg [`DSPIC_NSRC-1:0] latch_q; // Latched requests
  reg [`DSPIC_NSRC-1:0] prev_q; // Previous raw levels
  reg [`DSPIC_NSRC-1:0] insvc_q; // Levels in service
  reg [3:0] src_q; // Source being offered
  reg boot_q; // Reset vector owed
  reg mblk_q; // Mask-write blackout
  reg [`DSPIC_SPW-1:0] sp_q; // Stack pointer
  reg [`DSPIC_NSRC-1:0] raw; // Active-high request levels
  reg [`DSPIC_NSRC-1:0] lvl_mode; // One where level-sensed
  reg [`DSPIC_NSRC-1:0] pend;
  reg [`DSPIC_NSRC-1:0] elig;
  reg [3:0] sel;
  reg [3:0] top_isr;
  reg grant;
  wire wr_en;
  wire rd_en;
  wire hit;
  wire ack_take;
  wire do_push;
  wire do_pop;
  wire [`DSPIC_NSRC-1:0] fc_set;
  wire [`DSPIC_NSRC-1:0] fc_clr;
  wire [`DSPIC_NSRC-1:0] ack_clr;
  wire [`DSPIC_NSRC-1:0] isr_clr;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign hit = (paddr == `DSPIC_OFS_MASK) | (paddr == `DSPIC_OFS_CNTL) |
               (paddr == `DSPIC_OFS_FCLR) | (paddr == `DSPIC_OFS_GCTL) |
               (paddr == `DSPIC_OFS_PEND) | (paddr == `DSPIC_OFS_STAT);
  // Unmapped addresses answer with an error
  assign pslverr = psel & penable & ~hit;

  assign fc_set = (wr_en && paddr == `DSPIC_OFS_FCLR) ?
                  pwdata[`DSPIC_NSRC-1:0] : {`DSPIC_NSRC{1'b0}};
  assign fc_clr = (wr_en && paddr == `DSPIC_OFS_FCLR) ?
    pwdata[`DSPIC_FCLR_CLR_LSB+`DSPIC_NSRC-1:`DSPIC_FCLR_CLR_LSB] :
    {`DSPIC_NSRC{1'b0}};

  // ****************************************************************
  // Request collection
  // ****************************************************************
  // Pins are active low; alternates replace serial1 when enabled
  always @*
  begin
    raw = {`DSPIC_NSRC{1'b0}};
    lvl_mode = {`DSPIC_NSRC{1'b0}};
    raw[`DSPIC_SRC_PDN] = pdn_evt;
    raw[`DSPIC_SRC_EXTA] = ~ext_request_programmable_a_n;
    raw[`DSPIC_SRC_LVL2] = ~level_request_second_n;
    raw[`DSPIC_SRC_LVL1] = ~level_request_first_n;
    raw[`DSPIC_SRC_S0TX] = sp0_tx_evt;
    raw[`DSPIC_SRC_S0RX] = sp0_rx_evt;
    raw[`DSPIC_SRC_EDGE] = ~edge_request_pin_n;
    raw[`DSPIC_SRC_BYTE_DMA_PORT] = byte_dma_port_evt;
    raw[`DSPIC_SRC_TMR] = timer_evt;
    if (gctl_q[`DSPIC_GCTL_ALT])
    begin
      raw[`DSPIC_SRC_S1TX] = ~alt_request_transmit_sync_n;
      raw[`DSPIC_SRC_S1RX] = ~alt_request_receive_sync_n;
      lvl_mode[`DSPIC_SRC_S1TX] = ~cntl_q[`DSPIC_CNTL_TX_EDGE];
      lvl_mode[`DSPIC_SRC_S1RX] = ~cntl_q[`DSPIC_CNTL_RX_EDGE];
    end
    else
    begin
      raw[`DSPIC_SRC_S1TX] = sp1_tx_evt;
      raw[`DSPIC_SRC_S1RX] = sp1_rx_evt;
    end
    lvl_mode[`DSPIC_SRC_EXTA] = ~cntl_q[`DSPIC_CNTL_EXTA_EDGE];
    lvl_mode[`DSPIC_SRC_LVL2] = 1'b1;
    lvl_mode[`DSPIC_SRC_LVL1] = 1'b1;
  end

  // ****************************************************************
  // Selection
  // ****************************************************************
  always @*
  begin
    pend = latch_q | (raw & lvl_mode);
    elig = pend & {mask_q[`DSPIC_NSRC-1:1], 1'b1};
    sel = first_set(elig);
    top_isr = first_set(insvc_q);
    grant = 1'b0;
    if (sel != `DSPIC_NONE)
    begin
      if (cntl_q[`DSPIC_CNTL_NEST])
      begin
        grant = (sel < top_isr);
      end
      else
      begin
        grant = (insvc_q == {`DSPIC_NSRC{1'b0}});
      end
    end
    grant = grant & gctl_q[`DSPIC_GCTL_GIE] & ~mblk_q;
  end

  assign ack_take = irq_req_q & irq_ack;
  // push on entry, not for reset vector
  assign do_push = ack_take & ~boot_q & (sp_q != `DSPIC_SP_FULL);
  assign do_pop = irq_return & (sp_q != `DSPIC_SP_EMPTY);
  assign ack_clr = (ack_take & ~boot_q) ?
    ({{(`DSPIC_NSRC-1){1'b0}}, 1'b1} << src_q) : {`DSPIC_NSRC{1'b0}};
  assign isr_clr = (irq_return && top_isr != `DSPIC_NONE) ?
    ({{(`DSPIC_NSRC-1){1'b0}}, 1'b1} << top_isr) : {`DSPIC_NSRC{1'b0}};

  // ****************************************************************
  // Pending latches and edge detect
  // ****************************************************************
  // Set beats clear so no event is lost in the clearing cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_q <= {`DSPIC_NSRC{1'b0}};
      prev_q <= {`DSPIC_NSRC{1'b0}};
    end
    else
    begin
      prev_q <= raw;
      latch_q <= (latch_q & ~ack_clr & ~fc_clr) |
                 (raw & ~prev_q & ~lvl_mode) | fc_set;
    end
  end

  // ****************************************************************
  // Offer to the sequencer
  // ****************************************************************
  // Offer is withdrawn after ack so a stale latch is not re-offered
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_q <= 1'b1;
      irq_req_q <= 1'b0;
      irq_vector_q <= `DSPIC_VEC_RESET;
      src_q <= `DSPIC_NONE;
      insvc_q <= {`DSPIC_NSRC{1'b0}};
    end
    else
    begin
      insvc_q <= (insvc_q & ~isr_clr) | ack_clr;
      if (ack_take)
      begin
        irq_req_q <= 1'b0;
        boot_q <= 1'b0;
      end
      else if (boot_q || (powerup_evt && gctl_q[`DSPIC_GCTL_POWERUP_CONTEXT_RESET_BIT]))
      begin
        boot_q <= 1'b1;
        irq_req_q <= 1'b1;
        irq_vector_q <= `DSPIC_VEC_RESET;
        src_q <= `DSPIC_NONE;
      end
      else
      begin
        irq_req_q <= grant;
        irq_vector_q <= vec_of(sel);
        src_q <= sel;
      end
    end
  end

  // ****************************************************************
  // Status stack
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp_q <= `DSPIC_SP_EMPTY;
      stack_ovf_q <= 1'b0;
    end
    else
    begin
      if (do_push)
      begin
        sp_q <= sp_q + `DSPIC_SP_ONE;
      end
      else if (do_pop)
      begin
        sp_q <= sp_q - `DSPIC_SP_ONE;
      end
      // Entry with a full stack loses status; flag it
      if (ack_take && !boot_q && sp_q == `DSPIC_SP_FULL)
      begin
        stack_ovf_q <= 1'b1;
      end
    end
  end

  dspic_stack u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .we(do_push),
    .waddr(sp_q),
    .wdata(status_in),
    .re(do_pop),
    .raddr(sp_q - `DSPIC_SP_ONE),
    .rdata_q(status_out)
  );

  // ****************************************************************
  // Registers written by software
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_q <= `DSPIC_MASK_RST;
      cntl_q <= `DSPIC_CNTL_RST;
      gctl_q <= `DSPIC_GCTL_RST;
      mblk_q <= 1'b0;
      flag_out_q <= 1'b0;
    end
    else
    begin
      mblk_q <= wr_en && paddr == `DSPIC_OFS_MASK;
      flag_out_q <= gctl_q[`DSPIC_GCTL_FOUT];
      if (wr_en && paddr == `DSPIC_OFS_MASK)
      begin
        mask_q <= {pwdata[`DSPIC_NSRC-1:1], 1'b0};
      end
      else if (wr_en && paddr == `DSPIC_OFS_CNTL)
      begin
        cntl_q <= pwdata[4:0];
      end
      else if (wr_en && paddr == `DSPIC_OFS_GCTL)
      begin
        gctl_q <= pwdata[3:0];
      end
    end
  end

  // ****************************************************************
  // Read data, captured in the setup phase
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (rd_en)
    begin
      if (paddr == `DSPIC_OFS_MASK)
      begin
        prdata_q <= {21'h000000, mask_q};
      end
      else if (paddr == `DSPIC_OFS_CNTL)
      begin
        prdata_q <= {27'h0000000, cntl_q};
      end
      else if (paddr == `DSPIC_OFS_GCTL)
      begin
        prdata_q <= {28'h0000000, gctl_q};
      end
      else if (paddr == `DSPIC_OFS_PEND)
      begin
        prdata_q <= {21'h000000, pend};
      end
      else if (paddr == `DSPIC_OFS_STAT)
      begin
        prdata_q <= {5'h00, insvc_q, 9'h000, flag_in, stack_ovf_q,
                     boot_q, sp_q};
      end
      // Force/clear is write-only and reads zero
      else
      begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

endmodule
`default_nettype wire

/* verilog/dspic_defines.vh */
// Purpose: Shared constants of the DSP interrupt controller
// Assumes: Included by the controller and its status stack
// Notes: Byte offsets of the APB register map and field positions
`ifndef DSPIC_DEFINES_VH
`define DSPIC_DEFINES_VH

// ****************************************************************
// Bus and register map
// ****************************************************************
`define DSPIC_AW 8
`define DSPIC_OFS_MASK 8'h00
`define DSPIC_OFS_CNTL 8'h04
`define DSPIC_OFS_FCLR 8'h08
`define DSPIC_OFS_GCTL 8'h0c
`define DSPIC_OFS_PEND 8'h10
`define DSPIC_OFS_STAT 8'h14

// ****************************************************************
// Source indices, index 0 is the highest maskable-or-not level
// ****************************************************************
`define DSPIC_NSRC 11
`define DSPIC_SRC_PDN 0
`define DSPIC_SRC_EXTA 1
`define DSPIC_SRC_LVL2 2
`define DSPIC_SRC_LVL1 3
`define DSPIC_SRC_S0TX 4
`define DSPIC_SRC_S0RX 5
`define DSPIC_SRC_EDGE 6
`define DSPIC_SRC_BYTE_DMA_PORT 7
`define DSPIC_SRC_S1TX 8
`define DSPIC_SRC_S1RX 9
`define DSPIC_SRC_TMR 10
`define DSPIC_NONE 4'hf

// ****************************************************************
// Vector addresses
// ****************************************************************
`define DSPIC_VEC_RESET 14'h0000
`define DSPIC_VEC_EXTA 14'h0004
`define DSPIC_VEC_LVL2 14'h0008
`define DSPIC_VEC_LVL1 14'h000c
`define DSPIC_VEC_S0TX 14'h0010
`define DSPIC_VEC_S0RX 14'h0014
`define DSPIC_VEC_EDGE 14'h0018
`define DSPIC_VEC_BYTE_DMA_PORT 14'h001c
`define DSPIC_VEC_S1TX 14'h0020
`define DSPIC_VEC_S1RX 14'h0024
`define DSPIC_VEC_TMR 14'h0028
`define DSPIC_VEC_PDN 14'h002c

// ****************************************************************
// Control fields
// ****************************************************************
`define DSPIC_CNTL_RX_EDGE 0
`define DSPIC_CNTL_TX_EDGE 1
`define DSPIC_CNTL_EXTA_EDGE 2
`define DSPIC_CNTL_NEST 4
`define DSPIC_GCTL_GIE 0
`define DSPIC_GCTL_ALT 1
`define DSPIC_GCTL_POWERUP_CONTEXT_RESET_BIT 2
`define DSPIC_GCTL_FOUT 3
`define DSPIC_FCLR_CLR_LSB 16
`define DSPIC_MASK_RST 11'h000
`define DSPIC_CNTL_RST 5'h00
`define DSPIC_GCTL_RST 4'h1

// ****************************************************************
// Status stack
// ****************************************************************
`define DSPIC_SDEPTH 12
`define DSPIC_SPW 4
`define DSPIC_STW 16
`define DSPIC_SP_EMPTY 4'h0
`define DSPIC_SP_FULL 4'hc
`define DSPIC_SP_ONE 4'h1
`endif

/* verilog/dspic_stack.v */
// Purpose: Twelve-word status stack memory with registered read
// Assumes: Pointer kept by the controller
// Notes: Write and read may happen in the same cycle
`include "dspic_defines.vh"
`default_nettype none

module dspic_stack (
  input wire pclk,
  input wire presetn,
  input wire we,
  input wire [`DSPIC_SPW-1:0] waddr,
  input wire [`DSPIC_STW-1:0] wdata,
  input wire re,
  input wire [`DSPIC_SPW-1:0] raddr,
  output reg [`DSPIC_STW-1:0] rdata_q
);

  // Storage, no reset needed for array contents
  reg [`DSPIC_STW-1:0] mem [0:`DSPIC_SDEPTH-1];

  // ****************************************************************
  // Write port
  // ****************************************************************
  always @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // ****************************************************************
  // Registered read port
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= {`DSPIC_STW{1'b0}};
    end
    else if (re)
    begin
      rdata_q <= mem[raddr];
    end
  end

endmodule
`default_nettype wire
